// ===== mpg_gpio_bank.sv
// multi-port gpio bank with axi4-lite register slave
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - port 0 has eight pins, each independently input or output.
// - port 1 per-bit direction; two bits mask-ROM, eight bits flash.
// - port 2 has seven pins, each independently input or output.
// - port 2 bit 4 is open drain, only pulls low.
// - port 3 has five pins, each independently input or output.
// - ports 0,1,3 pull-up only when option bit set and pin input.
// - flash variant adds two-bit port 4, pins also interrupt inputs.
// - port 5 eight bits, no pull-up, lcd segments reversed order.
// - each port 2 pin except bit 4 switchable between port and control mode.
module mpg_gpio_bank
	import mpg_pkg::*;
#(
	parameter bit FLASH = 1'b1
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read channels
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// port pins: input level, output value, output enable
	input  wire logic [7:0]  p0_in,
	output logic [7:0]       p0_out,
	output logic [7:0]       p0_oe,
	output logic [7:0]       p0_pull_en,
	input  wire logic [7:0]  p1_in,
	output logic [7:0]       p1_out,
	output logic [7:0]       p1_oe,
	output logic [7:0]       p1_pull_en,
	input  wire logic [6:0]  p2_in,
	output logic [6:0]       p2_out,
	output logic [6:0]       p2_oe,
	input  wire logic [4:0]  p3_in,
	output logic [4:0]       p3_out,
	output logic [4:0]       p3_oe,
	output logic [4:0]       p3_pull_en,
	input  wire logic [1:0]  p4_in,
	output logic [1:0]       p4_out,
	output logic [1:0]       p4_oe,
	input  wire logic [7:0]  p5_in,
	output logic [7:0]       p5_out,
	output logic [7:0]       p5_oe,
	// alternate functions: peripheral side
	input  wire logic        buzzer_out,
	input  wire logic        clock_pulse_out,
	input  wire logic        serial_tx_line,
	input  wire logic [7:0]  lcd_segment_outputs,
	output logic             ext_irq_line_a,
	output logic             ext_irq_line_b,
	output logic             ext_irq_line_c,
	output logic             ext_irq_line_d,
	output logic             ext_irq_line_e,
	output logic             serial_rx_line
);
	localparam int P1W = FLASH ? MPG_P1_W_FLASH : MPG_P1_W_MASK;
	localparam logic [7:0] P1_MASK = 8'((16'h1 << P1W) - 16'h1);
	localparam logic [1:0] P4_MASK = FLASH ? 2'h3 : 2'h0;

	logic [7:0]  p0_lat_q, p1_lat_q, p5_lat_q, p0_dir_q, p1_dir_q, p5_dir_q;
	logic [6:0]  p2_lat_q, p2_dir_q, p2_ctl_q;
	logic [4:0]  p3_lat_q, p3_dir_q;
	logic [1:0]  p4_lat_q, p4_dir_q;
	logic [23:0] pull_up_option_reg_q;
	logic [7:0]  p5_lcd_q;
	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic        aw_ok_q, w_ok_q;
	logic [7:0]  lcd_rev;

	// write address and data captured independently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_q <= 1'b0;
			w_ok_q  <= 1'b0;
			aw_q    <= 8'h00;
			wd_q    <= 32'h0000_0000;
			ws_q    <= 4'h0;
		end else if (aw_ok_q && w_ok_q) begin
			aw_ok_q <= 1'b0;
			w_ok_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_q <= 1'b1;
				aw_q    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_q <= 1'b1;
				wd_q   <= s_axi_wdata;
				ws_q   <= s_axi_wstrb;
			end
		end
	end

	// ready high while the slot is free and no response is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_ok_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_ok_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	logic wr_go, wr_hit;
	assign wr_go = aw_ok_q && w_ok_q;
	assign wr_hit = aw_q[1:0] == 2'b00 && (aw_q[7:2] <= MPG_OFS_P5_LATCH[7:2]
		|| (aw_q[7:2] >= MPG_OFS_P0_DIR[7:2] && aw_q[7:2] <= MPG_OFS_P5_DIR[7:2])
		|| (aw_q[7:2] >= MPG_OFS_PULLUP[7:2] && aw_q[7:2] <= MPG_OFS_P5_LCD[7:2]));

	// register writes; low byte lane carries port data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p0_dir_q <= MPG_DIR_RST;
			p1_dir_q <= MPG_DIR_RST;
			p2_dir_q <= MPG_DIR_RST[6:0];
			p3_dir_q <= MPG_DIR_RST[4:0];
			p4_dir_q <= MPG_DIR_RST[1:0];
			p5_dir_q <= MPG_DIR_RST;
			p0_lat_q <= MPG_LATCH_RST;
			p1_lat_q <= MPG_LATCH_RST;
			p2_lat_q <= MPG_LATCH_RST[6:0];
			p3_lat_q <= MPG_LATCH_RST[4:0];
			p4_lat_q <= MPG_LATCH_RST[1:0];
			p5_lat_q <= MPG_LATCH_RST;
			p2_ctl_q <= MPG_CTRL_RST[6:0];
			p5_lcd_q <= MPG_CTRL_RST;
			pull_up_option_reg_q <= MPG_PULLUP_RST;
		end else if (wr_go) begin
			if (ws_q[0]) begin
				if (aw_q == MPG_OFS_P0_LATCH) p0_lat_q <= wd_q[7:0];
				else if (aw_q == MPG_OFS_P1_LATCH) p1_lat_q <= wd_q[7:0] & P1_MASK;
				else if (aw_q == MPG_OFS_P2_LATCH) p2_lat_q <= wd_q[6:0];
				else if (aw_q == MPG_OFS_P3_LATCH) p3_lat_q <= wd_q[4:0];
				else if (aw_q == MPG_OFS_P4_LATCH) p4_lat_q <= wd_q[1:0] & P4_MASK;
				else if (aw_q == MPG_OFS_P5_LATCH) p5_lat_q <= wd_q[7:0];
				else if (aw_q == MPG_OFS_P0_DIR) p0_dir_q <= wd_q[7:0];
				else if (aw_q == MPG_OFS_P1_DIR) p1_dir_q <= wd_q[7:0] | ~P1_MASK;
				else if (aw_q == MPG_OFS_P2_DIR) p2_dir_q <= wd_q[6:0];
				else if (aw_q == MPG_OFS_P3_DIR) p3_dir_q <= wd_q[4:0];
				else if (aw_q == MPG_OFS_P4_DIR) p4_dir_q <= wd_q[1:0] | ~P4_MASK;
				else if (aw_q == MPG_OFS_P5_DIR) p5_dir_q <= wd_q[7:0];
				else if (aw_q == MPG_OFS_P2_CTRL) p2_ctl_q <= wd_q[6:0];
				else if (aw_q == MPG_OFS_P5_LCD) p5_lcd_q <= wd_q[7:0];
				else if (aw_q == MPG_OFS_PULLUP) pull_up_option_reg_q[7:0] <= wd_q[7:0];
			end
			if (aw_q == MPG_OFS_PULLUP && ws_q[1])
				pull_up_option_reg_q[15:8] <= wd_q[15:8] & P1_MASK;
			if (aw_q == MPG_OFS_PULLUP && ws_q[2])
				pull_up_option_reg_q[20:16] <= wd_q[20:16];
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= MPG_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? MPG_RESP_OKAY : MPG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read mux: input pins return pin level, outputs the latch
	logic [31:0] rd_d;
	logic        rd_err;
	always_comb begin
		rd_d   = 32'h0000_0000;
		rd_err = 1'b0;
		if (s_axi_araddr == MPG_OFS_P0_LATCH)
			rd_d[7:0] = (p0_dir_q & p0_in) | (~p0_dir_q & p0_lat_q);
		else if (s_axi_araddr == MPG_OFS_P1_LATCH)
			rd_d[7:0] = ((p1_dir_q & p1_in) | (~p1_dir_q & p1_lat_q)) & P1_MASK;
		else if (s_axi_araddr == MPG_OFS_P2_LATCH)
			rd_d[6:0] = (p2_dir_q & p2_in) | (~p2_dir_q & p2_lat_q);
		else if (s_axi_araddr == MPG_OFS_P3_LATCH)
			rd_d[4:0] = (p3_dir_q & p3_in) | (~p3_dir_q & p3_lat_q);
		else if (s_axi_araddr == MPG_OFS_P4_LATCH)
			rd_d[1:0] = ((p4_dir_q & p4_in) | (~p4_dir_q & p4_lat_q)) & P4_MASK;
		else if (s_axi_araddr == MPG_OFS_P5_LATCH)
			rd_d[7:0] = (p5_dir_q & p5_in) | (~p5_dir_q & p5_lat_q);
		else if (s_axi_araddr == MPG_OFS_P0_DIR) rd_d[7:0] = p0_dir_q;
		else if (s_axi_araddr == MPG_OFS_P1_DIR) rd_d[7:0] = p1_dir_q;
		else if (s_axi_araddr == MPG_OFS_P2_DIR) rd_d[6:0] = p2_dir_q;
		else if (s_axi_araddr == MPG_OFS_P3_DIR) rd_d[4:0] = p3_dir_q;
		else if (s_axi_araddr == MPG_OFS_P4_DIR) rd_d[1:0] = p4_dir_q;
		else if (s_axi_araddr == MPG_OFS_P5_DIR) rd_d[7:0] = p5_dir_q;
		else if (s_axi_araddr == MPG_OFS_PULLUP) rd_d[23:0] = pull_up_option_reg_q;
		else if (s_axi_araddr == MPG_OFS_P2_CTRL) rd_d[6:0] = p2_ctl_q;
		else if (s_axi_araddr == MPG_OFS_P5_LCD) rd_d[7:0] = p5_lcd_q;
		else rd_err = 1'b1;
	end

	// read channel: one read at a time, data one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= MPG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_d;
			s_axi_rresp   <= rd_err ? MPG_RESP_SLVERR : MPG_RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// lcd segment order reversed onto port 5
	always_comb for (int i = 0; i < 8; i++) lcd_rev[i] = lcd_segment_outputs[7 - i];

	// pin drive registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p0_out <= 8'h00; p0_oe <= 8'h00; p0_pull_en <= 8'h00;
			p1_out <= 8'h00; p1_oe <= 8'h00; p1_pull_en <= 8'h00;
			p2_out <= 7'h00; p2_oe <= 7'h00;
			p3_out <= 5'h00; p3_oe <= 5'h00; p3_pull_en <= 5'h00;
			p4_out <= 2'h0;  p4_oe <= 2'h0;
			p5_out <= 8'h00; p5_oe <= 8'h00;
		end else begin
			p0_out <= p0_lat_q;
			p0_oe  <= ~p0_dir_q;
			p0_pull_en <= pull_up_option_reg_q[MPG_PU_P0_LSB +: 8] & p0_dir_q;
			p1_out <= p1_lat_q & P1_MASK;
			p1_oe  <= ~p1_dir_q & P1_MASK;
			p1_pull_en <= pull_up_option_reg_q[MPG_PU_P1_LSB +: 8] & p1_dir_q & P1_MASK;
			p3_out <= p3_lat_q;
			p3_oe  <= ~p3_dir_q;
			p3_pull_en <= pull_up_option_reg_q[MPG_PU_P3_LSB +: 5] & p3_dir_q;
			p4_out <= p4_lat_q & P4_MASK;
			p4_oe  <= ~p4_dir_q & P4_MASK;
			p5_out <= (p5_lcd_q & lcd_rev) | (~p5_lcd_q & p5_lat_q);
			p5_oe  <= p5_lcd_q | ~p5_dir_q;
			// port 2: control mode swaps in peripheral outputs
			p2_out <= {p2_lat_q[6],
				p2_ctl_q[5] ? serial_tx_line : p2_lat_q[5],
				1'b0,
				p2_ctl_q[3] ? clock_pulse_out : p2_lat_q[3],
				p2_ctl_q[2] ? buzzer_out : p2_lat_q[2],
				p2_lat_q[1:0]};
			p2_oe <= {~p2_dir_q[6],
				~p2_dir_q[5],
				~p2_dir_q[MPG_P2_OD_BIT] & ~p2_lat_q[MPG_P2_OD_BIT],
				~p2_dir_q[3:0]};
		end
	end

	// interrupt and serial receive routing; port 2 lines gated by control mode, port 4 lines by the flash variant
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_irq_line_a <= 1'b0;
			ext_irq_line_b <= 1'b0;
			ext_irq_line_c <= 1'b0;
			ext_irq_line_d <= 1'b0;
			ext_irq_line_e <= 1'b0;
			serial_rx_line <= 1'b1;
		end else begin
			ext_irq_line_a <= p2_ctl_q[0] & p2_in[0];
			ext_irq_line_b <= p2_ctl_q[1] & p2_in[1];
			ext_irq_line_c <= p2_ctl_q[2] & p2_in[2];
			ext_irq_line_d <= P4_MASK[0] & p4_in[0];
			ext_irq_line_e <= P4_MASK[1] & p4_in[1];
			serial_rx_line <= p2_ctl_q[6] ? p2_in[6] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== mpg_gpio_bank_bench.sv
// bench: registers, pins and alternate functions of the gpio bank
`timescale 1ns/1ns
`default_nettype none
module mpg_gpio_bank_bench;
	import mpg_pkg::*;
	// bus, pins, peripheral side
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_rx_line;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lcd_segment_outputs = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, pu;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, p4_in, p4_out, p4_oe, exp_b[$];
	logic [7:0] p0_in, p0_out, p0_oe, p0_pull_en, p1_in, p1_out, p1_oe, p1_pull_en;
	logic [7:0] p5_in, p5_out, p5_oe, m, od, rv, dv[6], lv[6];
	logic [6:0] p2_in, p2_out, p2_oe;
	logic [4:0] p3_in, p3_out, p3_oe, p3_pull_en;
	logic buzzer_out = 1'b0, clock_pulse_out = 1'b0, serial_tx_line = 1'b0;
	logic ext_irq_line_a, ext_irq_line_b, ext_irq_line_c, ext_irq_line_d, ext_irq_line_e;
	logic [47:0] ext_v = 48'h0, ext_e = 48'h0, all_in, all_oe, all_out;
	logic [33:0] exp_r[$];
	int fail_count = 0, total_checks = 0, cyc = 0, seed = 37470;
	localparam logic [7:0] WM[6] = '{8'hff, 8'hff, 8'h7f, 8'h1f, 8'h03, 8'hff};
	// one byte per port
	assign all_oe = {p5_oe, 6'h0, p4_oe, 3'h0, p3_oe, 1'h0, p2_oe, p1_oe, p0_oe};
	assign all_out = {p5_out, 6'h0, p4_out, 3'h0, p3_out, 1'h0, p2_out, p1_out, p0_out};
	assign {p5_in, p4_in, p3_in, p2_in, p1_in, p0_in} =
		{all_in[47:40], all_in[33:32], all_in[28:24], all_in[22:16], all_in[15:0]};
	mpg_gpio_bank #(.FLASH(1'b1)) i_dut (.*);
	mpg_pin_model #(.W(48)) i_board (.aclk, .d(all_out), .o(all_oe), .ev(ext_v), .ee(ext_e),
		.p({19'h0, p3_pull_en, 8'h0, p1_pull_en, p0_pull_en}), .l(all_in));
	always #5 aclk = ~aclk;
	// counted comparison
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		@(posedge aclk);
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// read, ready held from the request until data stands
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		@(posedge aclk);
		exp_r.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		ext_e <= '1;
		rd(MPG_OFS_P0_DIR, 32'hff);
		wr(8'h38, 32'h1, MPG_RESP_SLVERR);
		rd(8'h38, 32'h0, MPG_RESP_SLVERR);
		for (int r = 0; r < 4; r++) begin
			pu = $random(seed);
			ext_v <= 48'({$random(seed), $random(seed)});
			wr(MPG_OFS_PULLUP, pu);
			for (int i = 0; i < 6; i++) begin
				dv[i] = 8'($random(seed));
				lv[i] = 8'($random(seed));
				wr(8'(4 * i), {24'h0, lv[i]});
				wr(8'(32 + 4 * i), {24'h0, dv[i]});
			end
			repeat (3) @(posedge aclk);
			chk("pull", 34'({pu[20:16] & dv[3][4:0], pu[15:8] & dv[1], pu[7:0] & dv[0]}),
				34'({p3_pull_en, p1_pull_en, p0_pull_en}));
			for (int i = 0; i < 6; i++) begin
				m = WM[i];
				od = (i == 2) ? 8'h10 : 8'h00;
				chk("oe", 34'(~dv[i] & m & ~(od & lv[i])), 34'(all_oe[8*i +: 8]));
				chk("out", 34'(lv[i] & ~dv[i] & m & ~od), 34'(all_out[8*i +: 8] & ~dv[i] & m));
				rd(8'(4 * i), {24'h0, (ext_v[8*i +: 8] & dv[i] | lv[i] & ~dv[i]) & m});
			end
		end
		wr(MPG_OFS_P2_DIR, 32'h57);
		wr(MPG_OFS_P2_CTRL, 32'h6f);
		wr(MPG_OFS_P5_LCD, 32'hff);
		wr(MPG_OFS_P4_DIR, 32'h3);
		repeat (8) begin
			ext_v <= 48'({$random(seed), $random(seed)});
			{buzzer_out, clock_pulse_out, serial_tx_line, lcd_segment_outputs} <= 11'($random(seed));
			repeat (4) @(posedge aclk);
			for (int k = 0; k < 8; k++) rv[k] = lcd_segment_outputs[7 - k];
			chk("alt", 34'({ext_v[33:32], ext_v[18:16], ext_v[22], serial_tx_line,
				clock_pulse_out, buzzer_out}), 34'({ext_irq_line_e, ext_irq_line_d,
				ext_irq_line_c, ext_irq_line_b, ext_irq_line_a, serial_rx_line, p2_out[5],
				p2_out[3], p2_out[2]}));
			chk("lcd", 34'({8'hff, rv}), 34'({p5_oe, p5_out}));
		end
		end_of_test();
	end
	// response watcher and hang limit
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_rvalid && s_axi_rready) chk("rdata", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(exp_b.pop_front()), 34'(s_axi_bresp));
		if (cyc == 4000) begin
			fail_count++;
			end_of_test();
		end
	end
endmodule
`default_nettype wire

// ===== mpg_gpio_bank_properties.sv
// checker: port properties of the gpio bank
`timescale 1ns/1ns
`default_nettype none
module mpg_gpio_checker
	import mpg_pkg::*;
#(
	parameter bit FLASH = 1'b1
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes and read answer
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	// port 4 and its interrupt lines
	input wire logic [1:0]  p4_in,
	input wire logic [1:0]  p4_oe,
	input wire logic        ext_irq_line_d,
	input wire logic        ext_irq_line_e,
	// pins
	input wire logic [7:0]  p0_oe,
	input wire logic [7:0]  p0_pull_en,
	input wire logic [7:0]  p1_oe,
	input wire logic [7:0]  p1_pull_en,
	input wire logic [7:0]  p5_oe,
	input wire logic [6:0]  p2_oe,
	input wire logic [6:0]  p2_out,
	input wire logic [4:0]  p3_oe,
	input wire logic [4:0]  p3_pull_en
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// pin drive and pull-ups
	property p_od; !(p2_oe[MPG_P2_OD_BIT] && p2_out[MPG_P2_OD_BIT]); endproperty
	a_od: assert property (p_od) else $error("open-drain pin driven high");
	property p_pull; ~|{p0_pull_en & p0_oe, p1_pull_en & p1_oe, p3_pull_en & p3_oe}; endproperty
	a_pull: assert property (p_pull) else $error("pull-up on a driven pin");
	property p_rst; !$past(aresetn) |-> ~|{p0_oe, p1_oe, p2_oe, p3_oe, p4_oe, p5_oe}; endproperty
	a_rst: assert property (p_rst) else $error("pin driven after reset");
	property p_irq; (FLASH && $past(aresetn, 3) && $stable(p4_in)) [*3]
		|-> {ext_irq_line_e, ext_irq_line_d} == p4_in; endproperty
	a_irq: assert property (p_irq) else $error("port 4 not on irq lines");
	// register bus timing
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("write response late");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read data late");
	property p_rhold; s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rbusy: assert property (p_rbusy) else $error("read taken while data pending");
	property p_rstbus; !$past(aresetn)
		|-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready && !s_axi_arready; endproperty
	a_rstbus: assert property (p_rstbus) else $error("bus active after reset");
endmodule
bind mpg_gpio_bank mpg_gpio_checker #(.FLASH(FLASH)) i_chk (.*);
`default_nettype wire

// ===== mpg_pin_model.sv
// partner: board-side pin levels with pull-ups and floating lines
`timescale 1ns/1ns
`default_nettype none
module mpg_pin_model #(
	parameter int W = 48
) (
	// clock
	input  wire logic         aclk,
	// device side: value, enable, pull-up
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] o,
	input  wire logic [W-1:0] p,
	// board side: value, enable
	input  wire logic [W-1:0] ev,
	input  wire logic [W-1:0] ee,
	// resulting line level
	output logic [W-1:0]      l
);
	logic [W-1:0] f_q = '0;
	// an undriven line without pull-up wanders
	always_ff @(posedge aclk) f_q <= ~f_q;
	// device drive wins, then board, then pull-up
	always_comb for (int i = 0; i < W; i++) l[i] = o[i] ? d[i] : ee[i] ? ev[i] : p[i] | f_q[i];
endmodule
`default_nettype wire

// ===== mpg_pkg.sv
// package for the multi-port gpio bank: register map, widths, reset values
package mpg_pkg;
	// register byte offsets
	localparam logic [7:0] MPG_OFS_P0_LATCH  = 8'h00;
	localparam logic [7:0] MPG_OFS_P1_LATCH  = 8'h04;
	localparam logic [7:0] MPG_OFS_P2_LATCH  = 8'h08;
	localparam logic [7:0] MPG_OFS_P3_LATCH  = 8'h0c;
	localparam logic [7:0] MPG_OFS_P4_LATCH  = 8'h10;
	localparam logic [7:0] MPG_OFS_P5_LATCH  = 8'h14;
	localparam logic [7:0] MPG_OFS_P0_DIR    = 8'h20;
	localparam logic [7:0] MPG_OFS_P1_DIR    = 8'h24;
	localparam logic [7:0] MPG_OFS_P2_DIR    = 8'h28;
	localparam logic [7:0] MPG_OFS_P3_DIR    = 8'h2c;
	localparam logic [7:0] MPG_OFS_P4_DIR    = 8'h30;
	localparam logic [7:0] MPG_OFS_P5_DIR    = 8'h34;
	localparam logic [7:0] MPG_OFS_PULLUP    = 8'h40;
	localparam logic [7:0] MPG_OFS_P2_CTRL   = 8'h44;
	localparam logic [7:0] MPG_OFS_P5_LCD    = 8'h48;
	// pull-up option register field positions
	localparam int MPG_PU_P0_LSB = 0;
	localparam int MPG_PU_P1_LSB = 8;
	localparam int MPG_PU_P3_LSB = 16;
	// direction register: 1 = input; reset all inputs
	localparam logic [7:0] MPG_DIR_RST   = 8'hff;
	localparam logic [7:0] MPG_LATCH_RST = 8'h00;
	localparam logic [7:0] MPG_CTRL_RST  = 8'h00;
	localparam logic [23:0] MPG_PULLUP_RST = 24'h000000;
	localparam logic [1:0] MPG_RESP_OKAY   = 2'b00;
	localparam logic [1:0] MPG_RESP_SLVERR = 2'b10;
	localparam int MPG_P1_W_MASK  = 2;
	localparam int MPG_P1_W_FLASH = 8;
	// port 2 bit index of the open-drain pin
	localparam int MPG_P2_OD_BIT = 4;
endpackage
